// ### gpp_pkg.sv
package gpp_pkg;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_PIN_DIRECTION    = 8'h90;
	localparam logic [7:0] ADDR_PIN_OUTPUT_VALUE = 8'h91;
	localparam logic [7:0] ADDR_IRQ_DETECT_TYPE  = 8'h92;
	localparam logic [7:0] ADDR_PIN_IRQ_ENABLE   = 8'h94;
	localparam logic [7:0] ADDR_RISE_FLAGS       = 8'h95;
	localparam logic [7:0] ADDR_FALL_FLAGS       = 8'h96;
	localparam logic [7:0] ADDR_PIN_INPUT_LEVEL  = 8'h97;
	localparam logic [7:0] ADDR_LED_BLINK_SETUP  = 8'h98;

	// ****************************************************************
	// reset values and field layout
	// ****************************************************************
	localparam logic [3:0] RST_NIBBLE      = 4'h0;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam int         NUM_PINS        = 4;
	localparam int         NUM_LED_PINS    = 2;
	localparam int         LED1_MODE_BIT   = 6;
	localparam int         LED1_FLICK_LSB  = 4;
	localparam int         LED0_MODE_BIT   = 2;
	localparam int         LED0_FLICK_LSB  = 0;

	localparam logic [1:0] DETECT_LEVEL    = 2'h0;
	localparam logic [1:0] DETECT_RISE     = 2'h1;
	localparam logic [1:0] DETECT_FALL     = 2'h2;
	localparam logic [1:0] DETECT_BOTH     = 2'h3;

	localparam logic [1:0] FLICKER_OFF     = 2'h0;
	localparam logic [1:0] FLICKER_SLOW    = 2'h1;
	localparam logic [1:0] FLICKER_FAST    = 2'h2;
	localparam logic [1:0] FLICKER_ON      = 2'h3;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLOCK_HZ          = 200_000_000;
	localparam int CLOCK_MHZ         = 200;
	localparam int DEBOUNCE_TIME_NS  = 1000;
	localparam int DEBOUNCE_CYCLES   = (DEBOUNCE_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int BLINK_SLOW_HZ     = 1;
	localparam int BLINK_FAST_HZ     = 4;
	localparam int BLINK_DUTY_DIV    = 4;
	localparam int BLINK_SLOW_CYCLES = CLOCK_HZ / BLINK_SLOW_HZ;
	localparam int BLINK_FAST_CYCLES = CLOCK_HZ / BLINK_FAST_HZ;
	localparam int BLINK_CNT_W       = 28;

endpackage : gpp_pkg

// ### gpp_debounce.sv
`timescale 1ns/1ps
module gpp_debounce (
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	input  wire logic [3:0] i_level,
	output logic      [3:0] o_level
);

	// a pin level is accepted only after it held steady for the full window
	genvar gi;
	generate
		for (gi = 0; gi < gpp_pkg::NUM_PINS; gi++) begin : g_pin
			logic [7:0] cnt_ff;
			logic       lvl_ff;
			wire        differs = i_level[gi] ^ lvl_ff;
			wire        done    = (cnt_ff == 8'(gpp_pkg::DEBOUNCE_CYCLES - 1));

			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					cnt_ff <= 8'h00;
					lvl_ff <= 1'b0;
				end else if (!differs) begin
					cnt_ff <= 8'h00;
				end else if (done) begin
					cnt_ff <= 8'h00;
					lvl_ff <= i_level[gi];
				end else begin
					cnt_ff <= cnt_ff + 8'h01;
				end
			end
			assign o_level[gi] = lvl_ff;
		end
	endgenerate

endmodule : gpp_debounce

// ### gpp_led_blink.sv
`timescale 1ns/1ps
module gpp_led_blink #(
	parameter int P_SLOW_CYCLES = gpp_pkg::BLINK_SLOW_CYCLES,
	parameter int P_FAST_CYCLES = gpp_pkg::BLINK_FAST_CYCLES
) (
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	input  wire logic       i_power_on,
	input  wire logic [1:0] i_led_mode,
	input  wire logic [3:0] i_flicker,
	output logic      [1:0] o_lit
);

	localparam int W = gpp_pkg::BLINK_CNT_W;

	logic [W-1:0] slow_ff;
	logic [W-1:0] fast_ff;

	// free-running phase counters, shared by both led pins
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			slow_ff <= '0;
			fast_ff <= '0;
		end else begin
			slow_ff <= (slow_ff == W'(P_SLOW_CYCLES - 1)) ? '0 : slow_ff + W'(1);
			fast_ff <= (fast_ff == W'(P_FAST_CYCLES - 1)) ? '0 : fast_ff + W'(1);
		end
	end

	// quarter duty: lit during the first quarter of each period
	wire slow_on = slow_ff < W'(P_SLOW_CYCLES / gpp_pkg::BLINK_DUTY_DIV);
	wire fast_on = fast_ff < W'(P_FAST_CYCLES / gpp_pkg::BLINK_DUTY_DIV);

	genvar gi;
	generate
		for (gi = 0; gi < gpp_pkg::NUM_LED_PINS; gi++) begin : g_led
			wire [1:0] kind = i_flicker[2*gi +: 2];
			wire       flick = (kind == gpp_pkg::FLICKER_SLOW) ? slow_on :
			                   (kind == gpp_pkg::FLICKER_FAST) ? fast_on :
			                   (kind == gpp_pkg::FLICKER_ON);
			assign o_lit[gi] = i_led_mode[gi] ? flick : i_power_on;
		end
	endgenerate

endmodule : gpp_led_blink

// ### gpp_top.sv
`timescale 1ns/1ps
// Summary of operation
// - direction bit 0 input, 1 output; reset input
// - direction ignored in power-on signal mode
// - output bit 0 drives low, 1 high
// - open-drain output releases instead of driving high
// - output value only matters in output direction
// - two-bit field selects level/rise/fall/both detection
// - enable bit passes pin request, zero blocks
// - rising edge sets rise flag in rise/both
// - rise flag cleared by writing 0 only
// - level mode sets rise flag; clear blocked while high
// - falling edge sets fall flag in fall/both
// - fall flag cleared by writing 0 only
// - input register returns debounced level, read only
// - led mode bit and flicker field for pins 0,1
// - flicker off, 1Hz quarter, 4Hz quarter, on
// - summary request from enabled pin requests
module gpp_top #(
	parameter int P_SLOW_CYCLES = gpp_pkg::BLINK_SLOW_CYCLES,
	parameter int P_FAST_CYCLES = gpp_pkg::BLINK_FAST_CYCLES
) (
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	input  wire logic [3:0] i_gpio_pin,
	output logic      [3:0] o_gpio_out,
	output logic      [3:0] o_gpio_oe,
	input  wire logic [3:0] i_open_drain,
	input  wire logic [3:0] i_power_sig_mode,
	input  wire logic [1:0] i_led_function,
	input  wire logic [1:0] i_led_mode_default,
	input  wire logic       i_power_on,
	output logic            o_port_irq_summary
);

	// ****************************************************************
	// register file
	// ****************************************************************
	logic [3:0] pin_direction_ff;
	logic [3:0] pin_output_value_ff;
	logic [7:0] irq_detect_type_ff;
	logic [3:0] pin_irq_enable_ff;
	logic [3:0] rise_request_flags_ff;
	logic [3:0] fall_request_flags_ff;
	logic [1:0] led_mode_select_ff;
	logic [3:0] led_flicker_type_ff;
	logic       strap_taken_ff;
	logic [7:0] rdata_ff;

	wire wr_dir   = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_PIN_DIRECTION);
	wire wr_out   = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_PIN_OUTPUT_VALUE);
	wire wr_det   = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_IRQ_DETECT_TYPE);
	wire wr_en    = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_PIN_IRQ_ENABLE);
	wire wr_rise  = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_RISE_FLAGS);
	wire wr_fall  = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_FALL_FLAGS);
	wire wr_led   = i_reg_wr && (i_reg_addr == gpp_pkg::ADDR_LED_BLINK_SETUP);

	// ****************************************************************
	// pin input path
	// ****************************************************************
	logic [3:0] pin_meta_ff;
	logic [3:0] pin_sync_ff;
	logic [3:0] level_db;
	logic [3:0] level_prev_ff;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_meta_ff <= gpp_pkg::RST_NIBBLE;
			pin_sync_ff <= gpp_pkg::RST_NIBBLE;
		end else begin
			pin_meta_ff <= i_gpio_pin;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	gpp_debounce u_debounce (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_level   (pin_sync_ff),
		.o_level   (level_db)
	);

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			level_prev_ff <= gpp_pkg::RST_NIBBLE;
		end else begin
			level_prev_ff <= level_db;
		end
	end

	// ****************************************************************
	// request detection
	// ****************************************************************
	logic [3:0] rise_set;
	logic [3:0] fall_set;
	logic [3:0] level_req;
	logic [3:0] nxt_rise_flags;
	logic [3:0] nxt_fall_flags;

	genvar gi;
	generate
		for (gi = 0; gi < gpp_pkg::NUM_PINS; gi++) begin : g_det
			wire [1:0] detect_type_field = irq_detect_type_ff[2*gi +: 2];
			wire rose = level_db[gi] & ~level_prev_ff[gi];
			wire fell = ~level_db[gi] & level_prev_ff[gi];
			wire on_rise = (detect_type_field == gpp_pkg::DETECT_RISE) ||
			               (detect_type_field == gpp_pkg::DETECT_BOTH);
			wire on_fall = (detect_type_field == gpp_pkg::DETECT_FALL) ||
			               (detect_type_field == gpp_pkg::DETECT_BOTH);
			assign level_req[gi] = (detect_type_field == gpp_pkg::DETECT_LEVEL) &
			                       level_db[gi];
			assign rise_set[gi]  = (on_rise & rose) | level_req[gi];
			assign fall_set[gi]  = on_fall & fell;
		end
	endgenerate

	// a set in the same cycle as a clear wins, so no edge is lost
	assign nxt_rise_flags = (rise_request_flags_ff & ~(wr_rise ? ~i_reg_wdata[3:0] : 4'h0))
	                        | rise_set;
	assign nxt_fall_flags = (fall_request_flags_ff & ~(wr_fall ? ~i_reg_wdata[3:0] : 4'h0))
	                        | fall_set;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rise_request_flags_ff <= gpp_pkg::RST_NIBBLE;
			fall_request_flags_ff <= gpp_pkg::RST_NIBBLE;
		end else begin
			rise_request_flags_ff <= nxt_rise_flags;
			fall_request_flags_ff <= nxt_fall_flags;
		end
	end

	// summary is the unregistered or of enabled flags, no extra latency
	assign o_port_irq_summary = |((rise_request_flags_ff | fall_request_flags_ff)
	                              & pin_irq_enable_ff);

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_direction_ff    <= gpp_pkg::RST_NIBBLE;
			pin_output_value_ff <= gpp_pkg::RST_NIBBLE;
			irq_detect_type_ff  <= gpp_pkg::RST_BYTE;
			pin_irq_enable_ff   <= gpp_pkg::RST_NIBBLE;
		end else begin
			if (wr_dir) pin_direction_ff <= i_reg_wdata[3:0];
			if (wr_out) pin_output_value_ff <= i_reg_wdata[3:0];
			if (wr_det) irq_detect_type_ff <= i_reg_wdata;
			if (wr_en) pin_irq_enable_ff <= i_reg_wdata[3:0];
		end
	end

	// led mode default is a strap, caught on the first edge after release
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strap_taken_ff      <= 1'b0;
			led_mode_select_ff  <= 2'h0;
			led_flicker_type_ff <= gpp_pkg::RST_NIBBLE;
		end else begin
			strap_taken_ff <= 1'b1;
			if (wr_led) begin
				led_mode_select_ff  <= {i_reg_wdata[gpp_pkg::LED1_MODE_BIT],
				                        i_reg_wdata[gpp_pkg::LED0_MODE_BIT]};
				led_flicker_type_ff <= {i_reg_wdata[gpp_pkg::LED1_FLICK_LSB +: 2],
				                        i_reg_wdata[gpp_pkg::LED0_FLICK_LSB +: 2]};
			end else if (!strap_taken_ff) begin
				led_mode_select_ff <= i_led_mode_default;
			end
		end
	end

	// ****************************************************************
	// register read
	// ****************************************************************
	wire [7:0] led_read = {1'b0, led_mode_select_ff[1], led_flicker_type_ff[3:2],
	                       1'b0, led_mode_select_ff[0], led_flicker_type_ff[1:0]};
	logic [7:0] rd_mux;
	always_comb begin
		if (i_reg_addr == gpp_pkg::ADDR_PIN_DIRECTION)
			rd_mux = {4'h0, pin_direction_ff};
		else if (i_reg_addr == gpp_pkg::ADDR_PIN_OUTPUT_VALUE)
			rd_mux = {4'h0, pin_output_value_ff};
		else if (i_reg_addr == gpp_pkg::ADDR_IRQ_DETECT_TYPE)
			rd_mux = irq_detect_type_ff;
		else if (i_reg_addr == gpp_pkg::ADDR_PIN_IRQ_ENABLE)
			rd_mux = {4'h0, pin_irq_enable_ff};
		else if (i_reg_addr == gpp_pkg::ADDR_RISE_FLAGS)
			rd_mux = {4'h0, rise_request_flags_ff};
		else if (i_reg_addr == gpp_pkg::ADDR_FALL_FLAGS)
			rd_mux = {4'h0, fall_request_flags_ff};
		else if (i_reg_addr == gpp_pkg::ADDR_PIN_INPUT_LEVEL)
			rd_mux = {4'h0, level_db};
		else if (i_reg_addr == gpp_pkg::ADDR_LED_BLINK_SETUP)
			rd_mux = led_read;
		else
			rd_mux = 8'h00;
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_ff <= gpp_pkg::RST_BYTE;
		end else if (i_reg_rd) begin
			rdata_ff <= rd_mux;
		end
	end
	assign o_reg_rdata = rdata_ff;

	// ****************************************************************
	// pin output path
	// ****************************************************************
	logic [1:0] led_lit;
	logic [3:0] nxt_gpio_out;
	logic [3:0] nxt_gpio_oe;
	logic [3:0] gpio_out_ff;
	logic [3:0] gpio_oe_ff;

	gpp_led_blink #(
		.P_SLOW_CYCLES (P_SLOW_CYCLES),
		.P_FAST_CYCLES (P_FAST_CYCLES)
	) u_led_blink (
		.i_clock    (i_clock),
		.i_reset_n  (i_reset_n),
		.i_power_on (i_power_on),
		.i_led_mode (led_mode_select_ff),
		.i_flicker  (led_flicker_type_ff),
		.o_lit      (led_lit)
	);

	generate
		for (gi = 0; gi < gpp_pkg::NUM_PINS; gi++) begin : g_out
			wire led_pin = (gi < gpp_pkg::NUM_LED_PINS) ? i_led_function[gi % 2] : 1'b0;
			wire lit     = (gi < gpp_pkg::NUM_LED_PINS) ? led_lit[gi % 2] : 1'b0;
			wire power_on_signal_output_mode = i_power_sig_mode[gi];
			// power-on signal mode overrides the direction bit
			wire drives  = power_on_signal_output_mode | pin_direction_ff[gi];
			wire value   = power_on_signal_output_mode ? i_power_on
			                                           : pin_output_value_ff[gi];
			// an led pin sinks current when lit and floats when dark
			assign nxt_gpio_oe[gi]  = led_pin ? lit
			                        : drives & (~value | ~i_open_drain[gi]);
			assign nxt_gpio_out[gi] = led_pin ? 1'b0 : value;
		end
	endgenerate

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gpio_out_ff <= gpp_pkg::RST_NIBBLE;
			gpio_oe_ff  <= gpp_pkg::RST_NIBBLE;
		end else begin
			gpio_out_ff <= nxt_gpio_out;
			gpio_oe_ff  <= nxt_gpio_oe;
		end
	end
	assign o_gpio_out = gpio_out_ff;
	assign o_gpio_oe  = gpio_oe_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	generate
		for (gi = 0; gi < gpp_pkg::NUM_PINS; gi++) begin : g_chk
			wire plain = !i_power_sig_mode[gi] &&
			             !((gi < gpp_pkg::NUM_LED_PINS) && i_led_function[gi % 2]);
			wire [1:0] dt = irq_detect_type_ff[2*gi +: 2];

			sequence s_clear_write;
				wr_rise && !i_reg_wdata[gi];
			endsequence
			sequence s_rise_seen;
				level_db[gi] && !level_prev_ff[gi] && dt[0];
			endsequence

			AST_DIR_INPUT: assert property (plain && !pin_direction_ff[gi] |=> !o_gpio_oe[gi])
				else $error("input pin is driven");
			AST_POWER_SIG_DRIVES: assert property (
				i_power_sig_mode[gi] && !i_open_drain[gi] &&
				!((gi < 2) && i_led_function[gi % 2]) |=> o_gpio_oe[gi])
				else $error("power-on signal pin not driven");
			AST_OUT_LOW: assert property (
				plain && pin_direction_ff[gi] && !pin_output_value_ff[gi]
				|=> o_gpio_oe[gi] && !o_gpio_out[gi])
				else $error("output 0 not driven low");
			AST_OD_RELEASE: assert property (
				plain && pin_direction_ff[gi] && pin_output_value_ff[gi] && i_open_drain[gi]
				|=> !o_gpio_oe[gi])
				else $error("open-drain pin driven high");
			AST_RISE_SET: assert property (s_rise_seen |=> rise_request_flags_ff[gi])
				else $error("rising edge lost");
			AST_FALL_SET: assert property (
				!level_db[gi] && level_prev_ff[gi] && dt[1] |=> fall_request_flags_ff[gi])
				else $error("falling edge lost");
			AST_RISE_CLEAR: assert property (
				s_clear_write ##0 !rise_set[gi] |=> !rise_request_flags_ff[gi])
				else $error("rise flag not cleared");
			AST_FALL_NOSET: assert property (
				wr_fall && i_reg_wdata[gi] && !fall_set[gi] && !fall_request_flags_ff[gi]
				|=> !fall_request_flags_ff[gi])
				else $error("fall flag set by write");
			AST_LEVEL_HOLD: assert property (
				s_clear_write ##0 level_req[gi] |=> rise_request_flags_ff[gi])
				else $error("level request cleared while high");
		end
	endgenerate

	// a freshly set enabled rise or level request must reach the summary one cycle later
	AST_SUMMARY: assert property (
		|(rise_set & pin_irq_enable_ff) && !wr_en |=> o_port_irq_summary)
		else $error("enabled request missing from summary");
	AST_LEVEL_READ: assert property (
		i_reg_rd && i_reg_addr == gpp_pkg::ADDR_PIN_INPUT_LEVEL
		|=> o_reg_rdata == {4'h0, $past(level_db)})
		else $error("input level read wrong");

endmodule : gpp_top

// ### gpp_pin_model.sv
`timescale 1ns/1ps
module gpp_pin_model (
	input  wire logic [3:0] i_oe,
	input  wire logic [3:0] i_out,
	input  wire logic [3:0] i_ext_en,
	input  wire logic [3:0] i_ext_level,
	output logic      [3:0] o_pin,
	output logic      [1:0] o_led_lit
);
	// ****************************************************************
	// wire resolution
	// ****************************************************************
	// board pull-up: a released pin with nothing outside driving reads high,
	// so a wrongly released output shows up as a high level, never as a guess
	assign o_pin = (i_oe & i_out) | (~i_oe & ((i_ext_en & i_ext_level) | ~i_ext_en));

	// ****************************************************************
	// led load
	// ****************************************************************
	// led sinks current only while the device pulls the pin low
	assign o_led_lit = i_oe[1:0] & ~i_out[1:0];
endmodule : gpp_pin_model

// ### gpp_top_test.sv
`timescale 1ns/1ps
module gpp_top_test;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int P_SLOW = 16;
	localparam int P_FAST = 8;
	logic       clock;
	logic       reset_n;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [3:0] pin;
	logic [3:0] gpio_out;
	logic [3:0] gpio_oe;
	logic [3:0] pwr_sig;
	logic [1:0] led_fn;
	logic       power_on;
	logic       summary;
	logic [3:0] ext_en;
	logic [3:0] ext_level;
	logic [1:0] led_lit;
	int         num_errors;
	int         n_tests;
	int         cnt;
	logic [7:0] lit_exp [4] = '{8'h00, 8'h04, 8'h04, 8'h10};
	logic [7:0] zero_addr [8] = '{8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h93, 8'h99};

	gpp_top #(
		.P_SLOW_CYCLES (P_SLOW),
		.P_FAST_CYCLES (P_FAST)
	) uut (
		.i_clock            (clock),
		.i_reset_n          (reset_n),
		.i_reg_addr         (reg_addr),
		.i_reg_wr           (reg_wr),
		.i_reg_rd           (reg_rd),
		.i_reg_wdata        (reg_wdata),
		.o_reg_rdata        (reg_rdata),
		.i_gpio_pin         (pin),
		.o_gpio_out         (gpio_out),
		.o_gpio_oe          (gpio_oe),
		.i_open_drain       (4'h8),
		.i_power_sig_mode   (pwr_sig),
		.i_led_function     (led_fn),
		.i_led_mode_default (2'h2),
		.i_power_on         (power_on),
		.o_port_irq_summary (summary)
	);

	gpp_pin_model board (
		.i_oe        (gpio_oe),
		.i_out       (gpio_out),
		.i_ext_en    (ext_en),
		.i_ext_level (ext_level),
		.o_pin       (pin),
		.o_led_lit   (led_lit)
	);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic finish_test;
		if (num_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wait_cycles(input int n);
		repeat (n) @(negedge clock);
	endtask : wait_cycles

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clock);
		reg_addr  = addr;
		reg_wdata = data;
		reg_wr    = 1'b1;
		@(negedge clock);
		reg_wr    = 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge clock);
		reg_addr = addr;
		reg_rd   = 1'b1;
		@(negedge clock);
		reg_rd   = 1'b0;
		check(reg_rdata, exp);
	endtask : reg_read

	// pins are checked only where enabled; the value of a released pin is don't-care
	task automatic check_pins(input logic [7:0] exp);
		wait_cycles(2);
		check({gpio_oe, gpio_out & gpio_oe}, exp);
	endtask : check_pins

	// ****************************************************************
	// clock and watchdog
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		#200_000;
		num_errors++;
		finish_test();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		reset_n    = 1'b0;
		reg_addr   = 8'h00;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		reg_wdata  = 8'h00;
		pwr_sig    = 4'h0;
		led_fn     = 2'h0;
		power_on   = 1'b0;
		ext_en     = 4'hf;
		ext_level  = 4'h0;
		num_errors = 0;
		n_tests    = 0;
		wait_cycles(5);
		check({gpio_oe, gpio_out}, 8'h00);
		reset_n = 1'b1;
		foreach (zero_addr[i]) reg_read(zero_addr[i], 8'h00);
		reg_read(8'h98, 8'h40);
		// outputs, push-pull on pins 2..0, open drain on pin 3
		ext_en = 4'h0;
		reg_write(8'h90, 8'hff);
		reg_read(8'h90, 8'h0f);
		reg_write(8'h91, 8'h05);
		check_pins(8'hf5);
		reg_write(8'h91, 8'hff);
		reg_read(8'h91, 8'h0f);
		check_pins(8'h77);
		reg_write(8'h90, 8'h00);
		check_pins(8'h00);
		// power-on signal mode overrides the input direction
		pwr_sig  = 4'h4;
		power_on = 1'b1;
		check_pins(8'h44);
		power_on = 1'b0;
		check_pins(8'h40);
		pwr_sig  = 4'h0;
		// detection: pin3 level, pin2 both, pin1 fall, pin0 rise
		ext_en = 4'hf;
		wait_cycles(220);
		reg_write(8'h92, 8'h39);
		reg_read(8'h92, 8'h39);
		reg_write(8'h95, 8'h00);
		reg_write(8'h96, 8'h00);
		reg_read(8'h95, 8'h00);
		ext_level = 4'hf;
		wait_cycles(220);
		reg_read(8'h97, 8'h0f);
		reg_write(8'h97, 8'h00);
		reg_read(8'h97, 8'h0f);
		reg_read(8'h95, 8'h0d);
		reg_read(8'h96, 8'h00);
		reg_write(8'h95, 8'h00);
		reg_read(8'h95, 8'h08);
		reg_write(8'h96, 8'hff);
		reg_read(8'h96, 8'h00);
		reg_write(8'h94, 8'h07);
		wait_cycles(1);
		check({7'h00, summary}, 8'h00);
		reg_write(8'h94, 8'hff);
		reg_read(8'h94, 8'h0f);
		wait_cycles(1);
		check({7'h00, summary}, 8'h01);
		ext_level = 4'h0;
		wait_cycles(220);
		reg_read(8'h96, 8'h06);
		reg_write(8'h95, 8'hf7);
		reg_read(8'h95, 8'h00);
		check({7'h00, summary}, 8'h01);
		reg_write(8'h96, 8'h00);
		reg_read(8'h96, 8'h00);
		check({7'h00, summary}, 8'h00);
		// led on pin 0: follows power state, then each flicker type
		led_fn   = 2'h1;
		power_on = 1'b1;
		wait_cycles(2);
		check({6'h00, led_lit}, 8'h01);
		power_on = 1'b0;
		wait_cycles(2);
		check({6'h00, led_lit}, 8'h00);
		reg_write(8'h98, 8'hff);
		reg_read(8'h98, 8'h77);
		for (int f = 0; f < 4; f++) begin
			reg_write(8'h98, 8'h44 | 8'(f));
			wait_cycles(3);
			cnt = 0;
			// one slow period spans two fast ones, so the count is phase free
			repeat (P_SLOW) begin
				@(negedge clock);
				cnt += int'(led_lit[0] === 1'b1);
			end
			check(8'(cnt), lit_exp[f]);
		end
		// both led pins: both follow power, then pin 1 steady on by flicker
		led_fn   = 2'h3;
		power_on = 1'b1;
		reg_write(8'h98, 8'h30);
		wait_cycles(2);
		check({6'h00, led_lit}, 8'h03);
		power_on = 1'b0;
		reg_write(8'h98, 8'h70);
		wait_cycles(2);
		check({6'h00, led_lit}, 8'h02);
		finish_test();
	end
endmodule : gpp_top_test
